/* rtl/smap_defs.svh */
// constants of the shared memory access port: codes, offsets, reset values
`ifndef SMAP_DEFS_SVH
`define SMAP_DEFS_SVH

// shared function identifiers, one per cache path
`define SMAP_SFID_RENDER 2'h0
`define SMAP_SFID_SAMPLER 2'h1
`define SMAP_SFID_CONST 2'h2

// message types
`define SMAP_MT_BLOCK 3'h0
`define SMAP_MT_PAIR 3'h1
`define SMAP_MT_SCATTER 3'h2
`define SMAP_MT_STREAM 3'h3
`define SMAP_MT_FLUSH 3'h4

// binding slot selector that means stateless access
`define SMAP_BTI_STATELESS 8'hff

// surface descriptor codes and stateless overloads
`define SMAP_STYPE_BUFFER 2'h1
`define SMAP_FMT_4CH_FLOAT 4'h3
`define SMAP_PITCH_UNIT_BYTES 16
`define SMAP_STATELESS_PITCH 5'h01
`define SMAP_PAGE_SHIFT 12

// register offsets
`define SMAP_REG_GEN_BASE 12'h000
`define SMAP_REG_GEN_BOUND 12'h004
`define SMAP_REG_CTRL 12'h008
`define SMAP_REG_STATUS 12'h00c
`define SMAP_TBL_REGION 2'h1
`define SMAP_CTRL_EN_BIT 0

// reset values
`define SMAP_RST_GEN_BASE 32'h0000_0000
`define SMAP_RST_GEN_BOUND 32'hffff_ffff
`define SMAP_RST_CTRL_EN 1'b1

`endif

/* rtl/smap_pkg.sv */
// types of the shared memory access port
package smap_pkg;

   // surface descriptor as held in the binding table
   typedef struct packed {
      logic [11:0] base_page;
      logic [5:0] size_pages;
      logic [4:0] pitch_units;
      logic vstride;
      logic [3:0] fmt;
      logic tiled;
      logic fence;
      logic [1:0] stype;
   } smap_desc_t;

   // request message from a thread
   typedef struct packed {
      logic valid;
      logic [1:0] sfid;
      logic [2:0] mtype;
      logic write;
      logic commit;
      logic [7:0] bti;
      logic [5:0] thread;
      logic [7:0] dest;
      logic [31:0] off0;
      logic [31:0] off1;
      logic [3:0] mask;
      logic [127:0] wdata0;
      logic [127:0] wdata1;
   } smap_req_t;

   // one access toward a cache path
   typedef struct packed {
      logic valid;
      logic [1:0] sel;
      logic write;
      logic flush;
      logic [31:0] addr;
      logic tiled;
      logic fence;
      logic vstride;
      logic [4:0] pitch_units;
      logic [3:0] chan_mask;
      logic [127:0] wdata;
   } smap_cache_req_t;

   // reply toward the issuing thread
   typedef struct packed {
      logic valid;
      logic err;
      logic wr_reg;
      logic [5:0] thread;
      logic [7:0] dest;
      logic [127:0] data0;
      logic [127:0] data1;
   } smap_reply_t;

   typedef enum logic [2:0] {
      SMAP_ST_IDLE,
      SMAP_ST_LOOKUP,
      SMAP_ST_ISSUE,
      SMAP_ST_WAIT_RD,
      SMAP_ST_WAIT_FLUSH
   } smap_state_t;

endpackage

/* rtl/smap_mem.sv */
// binding table memory: one write port, one registered read port
`timescale 1ns/100ps
`default_nettype none
module smap_mem #(
   parameter int AW = 8,
   parameter int DW = 32
) (
   // clock and enable
   input wire logic clk,
   input wire logic ce,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset on the array; entries are undefined until software fills them
   always_ff @(posedge clk)
   begin
      if (ce && wr_en)
         mem[wr_addr] <= wr_data;
      if (ce && rd_en)
         rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

/* rtl/smap_port.sv */
// shared memory access port: message decode, surface lookup, cache issue
// Summary of operation
// - only the render path takes writes; every write goes there, linear or tiled.
// - sampler path is read-only and takes linear or tiled surfaces.
// - sampler path accesses need no flush against sampling engine use.
// - constant path is read-only, linear only, buffer surfaces only.
// - the cache path is chosen only by the targeted function identifier.
// - selector below 255 fetches the surface descriptor from the binding table.
// - selector 255 uses an untiled unfenced four-channel buffer, stride 0, pitch 16.
// - stateless address is shared origin plus offset, bounded by shared limit.
// - committed write replies once the write enters the in-order cache pipe.
// - after a commit reply later reads see the data, later writes supersede.
// - committed render flush replies only after the flush has completed.
// - commit reply leaves the register unchanged, only clears its dependency.
// - one thread's accesses proceed in issue order; cross-thread order is software's.
// - block, pair, scattered and streamed writes work on buffers, both models.
// - a pair read with equal indices makes a single cache access.
// - buffer messages move data without format conversion.
// - streamed vertex write uses the format only for the channel count.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "smap_defs.svh"
module smap_port #(
   parameter int TBL_AW = 8
) (
   // clock, reset and enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // request messages
   input wire smap_pkg::smap_req_t req,
   output logic req_ready,
   // cache paths
   output var smap_pkg::smap_cache_req_t cache_req,
   input wire logic cache_accept,
   input wire logic cache_rvalid,
   input wire logic [127:0] cache_rdata,
   input wire logic flush_done,
   // replies
   output var smap_pkg::smap_reply_t reply
);
   smap_pkg::smap_state_t state;
   smap_pkg::smap_state_t next_state;
   smap_pkg::smap_req_t cur;
   smap_pkg::smap_desc_t cur_desc;
   smap_pkg::smap_desc_t mem_q;
   smap_pkg::smap_desc_t desc_src;
   smap_pkg::smap_desc_t desc_eff;
   smap_pkg::smap_desc_t stateless_desc;
   logic [31:0] gen_base;
   logic [31:0] gen_bound;
   logic ctrl_en;
   logic [7:0] err_count;
   logic acc_idx;
   logic next_acc;
   logic load;
   logic finish;
   logic fin_err;
   logic [127:0] rbuf0;

   // register decode
   wire sel_base = reg_addr == `SMAP_REG_GEN_BASE;
   wire sel_bound = reg_addr == `SMAP_REG_GEN_BOUND;
   wire sel_ctrl = reg_addr == `SMAP_REG_CTRL;
   wire sel_status = reg_addr == `SMAP_REG_STATUS;
   wire sel_tbl = reg_addr[11:10] == `SMAP_TBL_REGION;
   wire tbl_wr = reg_wr && sel_tbl;
   wire busy = state != smap_pkg::SMAP_ST_IDLE;
   wire [31:0] status_word = {23'h000000, busy, err_count};
   // table entries are write-only; reading them returns zero like a hole
   wire [31:0] rd_mux = sel_base ? gen_base :
                        sel_bound ? gen_bound :
                        sel_ctrl ? {31'h00000000, ctrl_en} :
                        sel_status ? status_word : 32'h00000000;

   // software-visible registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         gen_base <= `SMAP_RST_GEN_BASE;
         gen_bound <= `SMAP_RST_GEN_BOUND;
         ctrl_en <= `SMAP_RST_CTRL_EN;
         reg_rdata <= 32'h00000000;
      end
      else if (ce)
      begin
         if (reg_wr && sel_base)
            gen_base <= reg_wdata;
         if (reg_wr && sel_bound)
            gen_bound <= reg_wdata;
         if (reg_wr && sel_ctrl)
            ctrl_en <= reg_wdata[`SMAP_CTRL_EN_BIT];
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000; // data only in the cycle after
      end
   end

   // binding table lookup, started as a request is taken
   wire take = state == smap_pkg::SMAP_ST_IDLE && req_ready && req.valid;
   smap_mem #(
      .AW(TBL_AW),
      .DW(32)
   ) u_tbl (
      .clk(clk),
      .ce(ce),
      .wr_en(tbl_wr),
      .wr_addr(reg_addr[TBL_AW+1:2]),
      .wr_data(reg_wdata),
      .rd_en(take),
      .rd_addr(req.bti[TBL_AW-1:0]),
      .rd_data(mem_q)
   );

   // surface selection: table entry or fixed stateless overloads
   always_comb
   begin
      stateless_desc = '0;
      stateless_desc.pitch_units = `SMAP_STATELESS_PITCH;
      stateless_desc.fmt = `SMAP_FMT_4CH_FLOAT;
      stateless_desc.stype = `SMAP_STYPE_BUFFER;
   end
   wire stateless = cur.bti == `SMAP_BTI_STATELESS;
   assign desc_src = (state == smap_pkg::SMAP_ST_LOOKUP) ? mem_q : cur_desc;
   assign desc_eff = stateless ? stateless_desc : desc_src;

   // address and bound of the access about to be loaded
   wire [31:0] off_next = next_acc ? cur.off1 : cur.off0;
   wire [31:0] page_base = {desc_eff.base_page, 20'h00000} >> (20 - `SMAP_PAGE_SHIFT);
   wire [31:0] size_bytes = {14'h0000, desc_eff.size_pages, 12'h000};
   wire [31:0] acc_addr = stateless ? gen_base + off_next : page_base + off_next;
   // stateless buffers have no size of their own, only the shared limit
   wire acc_oob = stateless ? (acc_addr >= gen_bound) : (off_next >= size_bytes);

   // message classification
   wire is_flush = cur.mtype == `SMAP_MT_FLUSH;
   wire is_stream = cur.mtype == `SMAP_MT_STREAM;
   wire is_pair = cur.mtype == `SMAP_MT_PAIR;
   wire merged = is_pair && !cur.write && cur.off0 == cur.off1;
   wire two_acc = is_pair && !merged;
   wire last_acc = !two_acc || acc_idx;
   wire bad_sfid = cur.sfid > `SMAP_SFID_CONST;
   wire bad_wr = cur.write && cur.sfid != `SMAP_SFID_RENDER;
   // a flush only makes sense on the render path; the sampler path never flushes
   wire bad_flush = is_flush && cur.sfid != `SMAP_SFID_RENDER;
   wire bad_type = cur.mtype > `SMAP_MT_FLUSH || (is_stream && !cur.write);
   wire bad_surf = !is_flush && desc_eff.stype != `SMAP_STYPE_BUFFER;
   wire bad_const = cur.sfid == `SMAP_SFID_CONST && desc_eff.tiled;
   wire bad = bad_sfid || bad_wr || bad_flush || bad_type || bad_surf || bad_const;

   // channel enables: formats only count channels, never convert
   wire [1:0] fmt_lo = desc_eff.fmt[1:0];
   wire [3:0] stream_mask = {fmt_lo == 2'h3, fmt_lo >= 2'h2, fmt_lo >= 2'h1, 1'b1};
   wire [3:0] chan_mask = is_stream ? stream_mask :
                          (cur.mtype == `SMAP_MT_SCATTER) ? cur.mask : 4'hf;

   // access progress
   wire accepted = cache_req.valid && cache_accept;
   wire issue_done = state == smap_pkg::SMAP_ST_ISSUE && (accepted || !cache_req.valid);

   // sequencing: one message at a time keeps each thread in issue order
   always_comb
   begin
      next_state = state;
      next_acc = acc_idx;
      load = 1'b0;
      finish = 1'b0;
      fin_err = 1'b0;
      case (state)
         smap_pkg::SMAP_ST_IDLE:
         begin
            if (take)
            begin
               next_state = smap_pkg::SMAP_ST_LOOKUP;
               next_acc = 1'b0;
            end
         end
         smap_pkg::SMAP_ST_LOOKUP:
         begin
            if (bad)
            begin
               finish = 1'b1;
               fin_err = 1'b1;
               next_state = smap_pkg::SMAP_ST_IDLE;
            end
            else
            begin
               load = 1'b1;
               next_state = smap_pkg::SMAP_ST_ISSUE;
            end
         end
         smap_pkg::SMAP_ST_ISSUE:
         begin
            if (issue_done)
            begin
               if (is_flush)
                  next_state = smap_pkg::SMAP_ST_WAIT_FLUSH;
               else if (!cur.write && cache_req.valid)
                  next_state = smap_pkg::SMAP_ST_WAIT_RD;
               else if (!last_acc)
               begin
                  next_acc = 1'b1;
                  load = 1'b1;
               end
               else
               begin
                  // entry into the in-order pipe is the commit point
                  finish = cur.commit || !cur.write;
                  next_state = smap_pkg::SMAP_ST_IDLE;
               end
            end
         end
         smap_pkg::SMAP_ST_WAIT_RD:
         begin
            if (cache_rvalid && !last_acc)
            begin
               next_acc = 1'b1;
               load = 1'b1;
               next_state = smap_pkg::SMAP_ST_ISSUE;
            end
            else if (cache_rvalid)
            begin
               finish = 1'b1;
               next_state = smap_pkg::SMAP_ST_IDLE;
            end
         end
         smap_pkg::SMAP_ST_WAIT_FLUSH:
         begin
            if (flush_done)
            begin
               finish = cur.commit;
               next_state = smap_pkg::SMAP_ST_IDLE;
            end
         end
         default:
            next_state = smap_pkg::SMAP_ST_IDLE;
      endcase
   end

   // state, current message and its descriptor
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= smap_pkg::SMAP_ST_IDLE;
         acc_idx <= 1'b0;
         cur <= '0;
         cur_desc <= '0;
         req_ready <= 1'b0;
      end
      else if (ce)
      begin
         state <= next_state;
         acc_idx <= next_acc;
         if (take)
            cur <= req;
         if (state == smap_pkg::SMAP_ST_LOOKUP)
            cur_desc <= desc_eff;
         req_ready <= next_state == smap_pkg::SMAP_ST_IDLE && ctrl_en;
      end
   end

   // cache access register; the path follows the identifier alone
   always_ff @(posedge clk)
   begin
      if (reset)
         cache_req <= '0;
      else if (ce)
      begin
         if (load)
         begin
            cache_req.valid <= is_flush || !acc_oob;
            cache_req.sel <= cur.sfid;
            cache_req.write <= cur.write;
            cache_req.flush <= is_flush;
            cache_req.addr <= is_flush ? 32'h00000000 : acc_addr;
            cache_req.tiled <= desc_eff.tiled;
            cache_req.fence <= desc_eff.fence;
            cache_req.vstride <= desc_eff.vstride;
            cache_req.pitch_units <= desc_eff.pitch_units;
            cache_req.chan_mask <= chan_mask;
            cache_req.wdata <= next_acc ? cur.wdata1 : cur.wdata0;
         end
         else if (accepted)
            cache_req.valid <= 1'b0;
      end
   end

   // read data: out-of-bounds accesses read as zero
   wire [127:0] rd_now = (state == smap_pkg::SMAP_ST_WAIT_RD) ? cache_rdata : 128'h0;
   wire cap0 = !acc_idx && two_acc && ((state == smap_pkg::SMAP_ST_WAIT_RD && cache_rvalid)
               || (issue_done && !cache_req.valid));
   wire rd_reply = !cur.write && !is_flush && !fin_err;
   wire [127:0] rep0 = two_acc ? rbuf0 : rd_now;
   wire [127:0] rep1 = (two_acc || merged) ? rd_now : 128'h0;

   // reply register and error counter
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reply <= '0;
         rbuf0 <= 128'h0;
         err_count <= 8'h00;
      end
      else if (ce)
      begin
         if (cap0)
            rbuf0 <= rd_now;
         reply.valid <= finish;
         if (finish)
         begin
            reply.err <= fin_err;
            reply.wr_reg <= rd_reply;
            reply.thread <= cur.thread;
            reply.dest <= cur.dest;
            reply.data0 <= rd_reply ? rep0 : 128'h0;
            reply.data1 <= rd_reply ? rep1 : 128'h0;
         end
         if (fin_err && err_count != 8'hff)
            err_count <= err_count + 8'h01;
      end
   end

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (reset || !ce);

   chk_write_render_only: assert property (
      cache_req.valid && cache_req.write |-> cache_req.sel == `SMAP_SFID_RENDER)
      else $error("write sent to a read-only cache path");
   chk_sampler_read_only: assert property (
      cache_req.valid && cache_req.sel == `SMAP_SFID_SAMPLER |->
      !cache_req.write && !cache_req.flush)
      else $error("sampler path got a write or flush");
   chk_const_linear_read: assert property (
      cache_req.valid && cache_req.sel == `SMAP_SFID_CONST |->
      !cache_req.write && !cache_req.tiled)
      else $error("constant path got a write or tiled access");
   chk_path_by_sfid: assert property (
      cache_req.valid |-> cache_req.sel == cur.sfid)
      else $error("cache path differs from function identifier");
   chk_table_address: assert property (
      cache_req.valid && !cache_req.flush && !stateless |->
      cache_req.addr == ({cur_desc.base_page, 12'h000} + (acc_idx ? cur.off1 : cur.off0)))
      else $error("descriptor address wrong");
   chk_stateless_address: assert property (
      cache_req.valid && !cache_req.flush && stateless |->
      cache_req.addr == gen_base + (acc_idx ? cur.off1 : cur.off0) && !cache_req.tiled
      && !cache_req.fence && !cache_req.vstride && cache_req.pitch_units == 5'h01)
      else $error("stateless access formed wrongly");
   chk_commit_reply: assert property (
      state == smap_pkg::SMAP_ST_ISSUE && accepted && cache_req.write && !cache_req.flush
      && cur.commit && last_acc |=> reply.valid && !reply.wr_reg && !reply.err)
      else $error("commit reply missing after write accepted");
   chk_flush_commit: assert property (
      state == smap_pkg::SMAP_ST_WAIT_FLUSH && !flush_done |=> !reply.valid)
      else $error("flush commit replied before flush done");
   chk_pair_merge: assert property (
      state == smap_pkg::SMAP_ST_ISSUE && acc_idx |-> !merged)
      else $error("equal pair read used two accesses");
   chk_one_in_flight: assert property (
      take |=> !req_ready ##1 (!req_ready || reply.valid))
      else $error("second message taken while one is open");
   chk_raw_write_data: assert property (
      cache_req.valid && cache_req.write |->
      cache_req.wdata == (acc_idx ? cur.wdata1 : cur.wdata0))
      else $error("write data altered");
   chk_stream_channels: assert property (
      cache_req.valid && is_stream |-> cache_req.chan_mask == stream_mask)
      else $error("stream channel count wrong");
   chk_reply_dest: assert property (
      reply.valid |-> reply.dest == cur.dest && reply.thread == cur.thread)
      else $error("reply routed to wrong destination");

   cov_commit_write: cover property (reply.valid && !reply.wr_reg && !reply.err);
   cov_flush_done: cover property (state == smap_pkg::SMAP_ST_WAIT_FLUSH && flush_done);
   cov_merged_pair: cover property (state == smap_pkg::SMAP_ST_LOOKUP && merged && !bad);
   cov_stateless_read: cover property (accepted && stateless && !cache_req.write);
endmodule
`default_nettype wire

/* testbench/smap_cache_model.sv */
// cache side model: takes accesses, stores writes, answers reads and flushes
`timescale 1ns/100ps
`default_nettype none
module smap_cache_model (
   // clock and stall length
   input wire logic clk,
   input wire logic [3:0] slow,
   // cache paths
   input wire smap_pkg::smap_cache_req_t cache_req,
   output logic cache_accept,
   output logic cache_rvalid,
   output logic [127:0] cache_rdata,
   output logic flush_done
);
   logic [127:0] mem [logic [31:0]];
   logic [127:0] rd_val = 128'h0;
   logic [3:0] wait_n = 4'h0;
   logic [3:0] rd_n = 4'h0;
   logic [3:0] fl_n = 4'h0;
   logic take;

   // one shared store, so every path sees the same data
   assign take = cache_req.valid && !cache_accept && wait_n >= slow;

   initial
   begin
      cache_accept = 1'b0;
      cache_rvalid = 1'b0;
      cache_rdata = 128'h0;
      flush_done = 1'b0;
   end

   // accept after the stall count; read data two cycles on, flush five
   always @(posedge clk)
   begin
      cache_accept <= take;
      wait_n <= (cache_req.valid && !cache_accept && !take) ? wait_n + 4'h1 : 4'h0;
      cache_rdata <= ~cache_rdata; // data lines invert each cycle, so the last answer comes back every second cycle
      if (cache_req.valid && cache_accept && cache_req.flush)
         fl_n <= 4'h5;
      else if (fl_n != 4'h0)
         fl_n <= fl_n - 4'h1;
      if (cache_req.valid && cache_accept && cache_req.write && !cache_req.flush)
         mem[cache_req.addr] = cache_req.wdata;
      if (cache_req.valid && cache_accept && !cache_req.write && !cache_req.flush)
         rd_val <= mem.exists(cache_req.addr) ? mem[cache_req.addr] : 128'h0;
      if (cache_req.valid && cache_accept && !cache_req.write && !cache_req.flush)
         rd_n <= 4'h2;
      else if (rd_n != 4'h0)
         rd_n <= rd_n - 4'h1;
      cache_rvalid <= (rd_n == 4'h1);
      if (rd_n == 4'h1)
         cache_rdata <= rd_val;
      flush_done <= (fl_n == 4'h1);
   end
endmodule
`default_nettype wire

/* testbench/tb_smap_port.sv */
// self-checking bench of the shared memory access port
`timescale 1ns/100ps
`default_nettype none
`include "smap_defs.svh"
module tb_smap_port;
   localparam logic [7:0] SL = `SMAP_BTI_STATELESS;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   smap_pkg::smap_req_t req = '0;
   logic req_ready;
   smap_pkg::smap_cache_req_t cache_req;
   logic cache_accept;
   logic cache_rvalid;
   logic [127:0] cache_rdata;
   logic flush_done;
   smap_pkg::smap_reply_t reply;
   smap_pkg::smap_reply_t rp;
   smap_pkg::smap_req_t r;
   smap_pkg::smap_cache_req_t acc_q[$];
   logic [127:0] exp_mem [int];
   logic [3:0] slow = 4'h0;
   logic fd_seen = 1'b0;
   int miscompares = 0;
   int cmp_count = 0;
   int k;
   logic [1:0] bad_sf [8] = '{2'h1, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h2, 2'h0};
   logic [2:0] bad_mt [8] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h5, 3'h3, 3'h0, 3'h0};
   logic [7:0] bad_bt [8] = '{SL, SL, SL, SL, SL, SL, 8'h03, 8'h04};

   smap_port #(.TBL_AW(8)) u_smap_port (.clk(clk), .reset(reset), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .req(req), .req_ready(req_ready), .cache_req(cache_req),
      .cache_accept(cache_accept), .cache_rvalid(cache_rvalid), .cache_rdata(cache_rdata),
      .flush_done(flush_done), .reply(reply));
   smap_cache_model u_smap_cache_model (.clk(clk), .slow(slow), .cache_req(cache_req),
      .cache_accept(cache_accept), .cache_rvalid(cache_rvalid), .cache_rdata(cache_rdata),
      .flush_done(flush_done));

   // 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // log each access the cache takes and each finished flush
   always @(posedge clk)
   begin
      if (cache_req.valid && cache_accept)
         acc_q.push_back(cache_req);
      if (flush_done)
         fd_seen <= 1'b1;
   end

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic give_up();
      miscompares++;
      test_done();
   endtask

   task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check("reg_rdata", {96'h0, reg_rdata}, {96'h0, exp});
   endtask

   function automatic smap_pkg::smap_req_t mk(input logic [1:0] sf, input logic [2:0] mt,
      input logic wr, input logic cm, input logic [7:0] bt, input logic [31:0] o0,
      input logic [31:0] o1);
      smap_pkg::smap_req_t q;
      q = '0;
      q.valid = 1'b1;
      q.sfid = sf;
      q.mtype = mt;
      q.write = wr;
      q.commit = cm;
      q.bti = bt;
      q.off0 = o0;
      q.off1 = o1;
      q.mask = 4'h5;
      q.thread = 6'($urandom);
      q.dest = 8'($urandom);
      q.wdata0 = {$urandom, $urandom, $urandom, $urandom};
      q.wdata1 = {$urandom, $urandom, $urandom, $urandom};
      return q;
   endfunction

   // one message at a time: held until taken, then wait for its reply if one is wanted
   task automatic send(input smap_pkg::smap_req_t q, input bit want);
      int i;
      @(posedge clk);
      req <= q;
      acc_q.delete();
      @(negedge clk);
      for (i = 0; req_ready !== 1'b1; i++)
      begin
         if (i == 50)
            give_up();
         @(negedge clk);
      end
      @(posedge clk);
      req.valid <= 1'b0;
      rp = '0;
      for (i = 0; want && rp.valid !== 1'b1; i++)
      begin
         if (i == 200)
            give_up();
         @(negedge clk);
         rp = reply;
      end
   endtask

   task automatic read_chk(input smap_pkg::smap_req_t q, input logic [127:0] e0,
      input logic [127:0] e1);
      send(q, 1'b1);
      check("data0", rp.data0, e0);
      check("data1", rp.data1, e1);
      check("rd reply", {rp.wr_reg, rp.err, rp.dest}, {2'b10, q.dest});
   endtask

   initial
   begin
      void'($urandom(10));
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      reg_read(`SMAP_REG_GEN_BASE, `SMAP_RST_GEN_BASE);
      reg_read(`SMAP_REG_GEN_BOUND, `SMAP_RST_GEN_BOUND);
      reg_read(`SMAP_REG_CTRL, 32'h1);
      reg_read(12'h010, 32'h0);
      reg_write(`SMAP_REG_GEN_BASE, 32'h1000);
      reg_write(`SMAP_REG_GEN_BOUND, 32'h2000);
      reg_read(`SMAP_REG_GEN_BASE, 32'h1000);
      reg_write(12'h40c, {12'h002, 6'h01, 5'h04, 1'b1, 4'h1, 1'b1, 1'b1, `SMAP_STYPE_BUFFER});
      reg_write(12'h410, 32'h0000_4000);
      // committed stateless writes against a stalling and a prompt cache
      for (k = 0; k < 4; k++)
      begin
         slow <= 4'(k);
         r = mk(`SMAP_SFID_RENDER, `SMAP_MT_BLOCK, 1'b1, 1'b1, SL, 32'(k * 16), 32'h0);
         send(r, 1'b1);
         exp_mem[32'h1000 + k * 16] = r.wdata0;
         check("commit", {rp.wr_reg, rp.err, rp.thread, rp.dest}, {2'b00, r.thread, r.dest});
         check("count", acc_q.size(), 1);
         check("stateless", {acc_q[0].sel, acc_q[0].addr, acc_q[0].tiled, acc_q[0].fence,
            acc_q[0].vstride, acc_q[0].pitch_units},
            {`SMAP_SFID_RENDER, 32'(32'h1000 + k * 16), 3'b000, `SMAP_STATELESS_PITCH});
      end
      slow <= 4'h1;
      r = mk(`SMAP_SFID_RENDER, `SMAP_MT_PAIR, 1'b1, 1'b0, SL, 32'h30, 32'h40);
      send(r, 1'b0);
      exp_mem[32'h1030] = r.wdata0;
      exp_mem[32'h1040] = r.wdata1;
      // read back newest first, through the writing path
      for (k = 4; k >= 0; k--)
         read_chk(mk(2'h0, 3'h0, 1'b0, 1'b0, SL, 32'(k * 16), 32'h0),
            exp_mem[32'h1000 + k * 16], 128'h0);
      // each function identifier picks its own cache path
      for (k = 0; k < 3; k++)
      begin
         read_chk(mk(2'(k), 3'h0, 1'b0, 1'b0, SL, 32'h0, 32'h0), exp_mem[32'h1000], 128'h0);
         check("path", {acc_q.size(), acc_q[0].sel}, {32'd1, 2'(k)});
      end
      // refused messages answer with an error and reach no cache
      for (k = 0; k < 8; k++)
      begin
         send(mk(bad_sf[k], bad_mt[k], k < 2, 1'b0, bad_bt[k], 32'h0, 32'h0), 1'b1);
         check("refuse", {rp.err, rp.wr_reg, acc_q.size()}, {2'b10, 32'd0});
      end
      reg_read(`SMAP_REG_STATUS, 32'h8);
      // past the shared limit: no access, zero data; never committed
      read_chk(mk(2'h0, 3'h0, 1'b0, 1'b0, SL, 32'h1000, 32'h0), 128'h0, 128'h0);
      check("oob", acc_q.size(), 0);
      read_chk(mk(2'h0, 3'h1, 1'b0, 1'b0, SL, 32'h0, 32'h0), exp_mem[32'h1000],
         exp_mem[32'h1000]);
      check("merge", acc_q.size(), 1);
      read_chk(mk(2'h0, 3'h1, 1'b0, 1'b0, SL, 32'h10, 32'h0), exp_mem[32'h1010],
         exp_mem[32'h1000]);
      check("pair", {acc_q.size(), acc_q[0].addr, acc_q[1].addr}, {32'd2, 64'h1010_0000_1000});
      // descriptor lookup gives place, tiling, fence, stride and pitch
      read_chk(mk(2'h0, 3'h0, 1'b0, 1'b0, 8'h03, 32'h10, 32'h0), 128'h0, 128'h0);
      check("desc", {acc_q[0].addr, acc_q[0].tiled, acc_q[0].fence, acc_q[0].vstride,
         acc_q[0].pitch_units}, {32'h2010, 3'b111, 5'h04});
      // channel counts: streamed by format, scattered by mask
      send(mk(2'h0, 3'h3, 1'b1, 1'b1, 8'h03, 32'h20, 32'h0), 1'b1);
      check("stream fmt1", {acc_q[0].write, acc_q[0].chan_mask}, 5'h13);
      send(mk(2'h0, 3'h3, 1'b1, 1'b1, SL, 32'h40, 32'h0), 1'b1);
      check("stream fmt3", {acc_q[0].write, acc_q[0].chan_mask}, 5'h1f);
      send(mk(2'h0, 3'h2, 1'b1, 1'b1, SL, 32'h50, 32'h0), 1'b1);
      check("scatter", {acc_q[0].write, acc_q[0].chan_mask}, 5'h15);
      // committed flush answers only once the flush has finished
      slow <= 4'h2;
      fd_seen <= 1'b0;
      send(mk(2'h0, `SMAP_MT_FLUSH, 1'b0, 1'b1, SL, 32'h0, 32'h0), 1'b1);
      check("flush", {fd_seen, rp.err, rp.wr_reg, acc_q[0].flush}, 4'b1001);
      test_done();
   end
endmodule
`default_nettype wire
